// ==== rtl/clutch_pkg.sv ====
// register map, field layout, mode codes and state types of the clutch control block
// assumes a 32-bit apb master and one operation-cycle tick from the motion core
package clutch_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_ON_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] REG_OFF_ADDR = 12'h008;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h00C;

  // control register fields
  localparam int CTRL_CMD_BIT = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_MODE_MSB = 6;
  localparam int CTRL_SEL_LSB = 8;
  localparam int CTRL_SEL_MSB = 9;
  localparam int CTRL_ERREN_BIT = 12;

  // status register fields
  localparam int STAT_CLUTCH_BIT = 0;
  localparam int STAT_MODEERR_BIT = 1;
  localparam int STAT_ERRLATCH_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_MODE_MSB = 6;

  // clutch operation mode codes
  localparam logic [2:0] MODE_ONOFF = 3'h0;
  localparam logic [2:0] MODE_ADDR = 3'h1;
  localparam logic [2:0] MODE_ADDR2 = 3'h2;
  localparam logic [2:0] MODE_OS_EN = 3'h3;
  localparam logic [2:0] MODE_OS_DIS = 3'h4;
  localparam logic [2:0] MODE_MAX = 3'h4;

  // compare-value sources
  localparam logic [1:0] SEL_VIRT = 2'h0;
  localparam logic [1:0] SEL_DIFF = 2'h1;
  localparam logic [1:0] SEL_REV = 2'h2;

  // reset values
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic [31:0] RST_ADDR = 32'h00000000;

  typedef enum logic [1:0] {PH_IDLE, PH_PRE, PH_POST} phase_type;

  // positions offered by the drive side, all sampled per operation cycle
  typedef struct packed {
    logic signed [31:0] virt;
    logic signed [31:0] diff;
    logic signed [31:0] rev;
  } axis_pos_type;

  // complete state of the block
  typedef struct packed {
    logic cmd;
    logic [2:0] mode;
    logic [1:0] pos_sel;
    logic err_en;
    logic signed [31:0] on_addr;
    logic signed [31:0] off_addr;
    logic mode_err;
    logic clutch;
    logic status;
    logic err_latch;
    phase_type phase;
    logic signed [31:0] base;
    logic signed [31:0] pre_amt;
    logic signed [31:0] post_amt;
    logic cmd_prev;
    logic [2:0] mode_prev;
    logic signed [31:0] prev_pos;
    logic pos_valid;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic servo_ok;
  } state_type;

endpackage : clutch_pkg

// ==== rtl/clutch_ctrl.sv ====
// virtual clutch controller for one output axis, with apb register access
// assumes op_tick pulses once per operation cycle and positions are valid then
//
// How it works
// RL1: mode codes above four are refused and the old mode stays active
// RL2: a new mode code takes effect at once, whatever the clutch is doing
// RL3: status flag shows clutch state and is refreshed each operation cycle
// RL4: mode 1 with command on engages when the ON address is reached
// RL5: mode 1 with command off releases at the OFF address; other address ignored
// RL6: compare value is axis value, differential output, or within-revolution value
// RL7: ON and OFF addresses are signed 32-bit words, usable immediately after write
// RL8: host loads addresses before toggling the command in address mode
// RL9: mode 2 with command on alternates between ON and OFF address monitoring
// RL10: mode 2 with command off forces clutch off and pauses alternation
// RL11: one evaluation per cycle; passing both addresses keeps status unchanged
// RL12: major error with release selected drops clutch; resume needs command off then on
// RL13: host drops command before servo off; servo off granted only with clutch off
// RL14: host restores power, servo on, then command to resume monitoring
// RL15: one-shot control runs for mode 3 and mode 4
// RL16: mode 3 command rise counts pre-engage travel, then post-engage travel
// RL17: command fall in one-shot mode leaves the running sequence alone
// RL18: mode 4 keeps clutch off but finishes a sequence started under mode 3
// RL19: ON address word holds signed post-engage travel in one-shot mode
// RL20: OFF address word holds signed pre-engage travel in one-shot mode
// RL21: zero pre-engage travel engages in the same cycle as the command rise
// RL22: address reached when between previous and present value, inclusive
`timescale 1ns/1ps

module clutch_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clutch_pkg::ADDR_W-1:0] paddr,
  input wire logic [clutch_pkg::DATA_W-1:0] pwdata,
  output logic [clutch_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive side
  input wire logic op_tick,
  input wire clutch_pkg::axis_pos_type axis_pos,
  input wire logic major_err,
  // servo side
  input wire logic servo_off_req,
  output logic servo_off_ok,
  // clutch outputs
  output logic clutch_on,
  output logic clutch_status
);
  import clutch_pkg::*;

  state_type st;
  state_type next_st;
  logic signed [31:0] cur;
  logic on_hit;
  logic off_hit;
  logic rise;
  logic wr_ctrl;
  logic tick_ok;

  // true when addr lies between p and c inclusive, either direction
  function automatic logic between(input logic signed [31:0] addr,
                                   input logic signed [31:0] p,
                                   input logic signed [31:0] c);
    logic r;
    if (p <= c)
    begin
      r = (addr >= p) && (addr <= c);
    end
    else
    begin
      r = (addr <= p) && (addr >= c);
    end
    return r;
  endfunction : between

  // travel has covered a signed target; sign of target picks direction
  function automatic logic reached(input logic signed [31:0] travel,
                                   input logic signed [31:0] target);
    logic r;
    if (target[31])
    begin
      r = travel <= target;
    end
    else
    begin
      r = travel >= target;
    end
    return r;
  endfunction : reached

  // compare value source; within-revolution only makes sense for rotary or cam outputs
  always_comb
  begin
    case (st.pos_sel)
      SEL_DIFF: cur = axis_pos.diff; // [RL6]
      SEL_REV: cur = axis_pos.rev; // [RL6]
      default: cur = axis_pos.virt; // [RL6]
    endcase
  end

  // address reach detection over the last cycle's travel
  assign on_hit = st.pos_valid && between(st.on_addr, st.prev_pos, cur); // [RL22]
  assign off_hit = st.pos_valid && between(st.off_addr, st.prev_pos, cur); // [RL22]
  // a fresh start: command rise, or mode 3 entered with command already on
  // only the rise is decoded, so a command fall never disturbs a running sequence
  assign rise = st.cmd && (!st.cmd_prev || st.mode_prev != MODE_OS_EN); // [RL17]
  assign wr_ctrl = psel && penable && st.pready && pwrite && paddr == REG_CTRL;
  assign tick_ok = op_tick && !st.err_latch && !major_err;

  // next-state logic: bus side first, then the per-cycle clutch evaluation
  always_comb
  begin
    logic c;
    logic latch;
    phase_type ph;
    logic signed [31:0] b;
    next_st = st;
    c = st.clutch;
    latch = st.err_latch;
    ph = st.phase;
    b = st.base;

    // two-cycle access: pready rises one cycle into the access phase
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (psel && penable && !st.pready)
    begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h00000000;
      case (paddr)
        REG_CTRL:
        begin
          next_st.prdata[CTRL_CMD_BIT] = st.cmd;
          next_st.prdata[CTRL_MODE_MSB:CTRL_MODE_LSB] = st.mode;
          next_st.prdata[CTRL_SEL_MSB:CTRL_SEL_LSB] = st.pos_sel;
          next_st.prdata[CTRL_ERREN_BIT] = st.err_en;
        end
        REG_ON_ADDR: next_st.prdata = st.on_addr;
        REG_OFF_ADDR: next_st.prdata = st.off_addr;
        REG_STATUS:
        begin
          next_st.prdata[STAT_CLUTCH_BIT] = st.status; // [RL3]
          next_st.prdata[STAT_MODEERR_BIT] = st.mode_err;
          next_st.prdata[STAT_ERRLATCH_BIT] = st.err_latch;
          next_st.prdata[STAT_BUSY_BIT] = st.phase != PH_IDLE;
          next_st.prdata[STAT_MODE_MSB:STAT_MODE_LSB] = st.mode;
        end
        default: next_st.pslverr = 1'b1; // unmapped address
      endcase
    end

    // writes land at the completing edge only
    if (psel && penable && st.pready && pwrite)
    begin
      case (paddr)
        REG_CTRL:
        begin
          next_st.cmd = pwdata[CTRL_CMD_BIT];
          next_st.pos_sel = pwdata[CTRL_SEL_MSB:CTRL_SEL_LSB];
          next_st.err_en = pwdata[CTRL_ERREN_BIT];
          if (pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB] <= MODE_MAX)
          begin
            next_st.mode = pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB]; // [RL2]
          end
        end
        REG_ON_ADDR: next_st.on_addr = pwdata; // [RL7]
        REG_OFF_ADDR: next_st.off_addr = pwdata; // [RL7]
        REG_STATUS:
        begin
          if (pwdata[STAT_MODEERR_BIT])
          begin
            next_st.mode_err = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // bad mode code flagged after the clear so a fresh error is never lost
    if (wr_ctrl && pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB] > MODE_MAX)
    begin
      next_st.mode_err = 1'b1; // [RL1]
    end

    // clutch evaluation, once per operation cycle
    if (op_tick)
    begin
      // error latch clears only after error gone and command taken low
      if (latch && !major_err && !st.cmd)
      begin
        latch = 1'b0; // [RL12]
      end
      if (major_err && st.err_en)
      begin
        latch = 1'b1; // [RL12]
      end
      case (st.mode)
        MODE_ONOFF:
        begin
          c = st.cmd;
          ph = PH_IDLE;
        end
        MODE_ADDR:
        begin
          ph = PH_IDLE;
          if (st.cmd && on_hit)
          begin
            c = 1'b1; // [RL4]
          end
          else if (!st.cmd && off_hit)
          begin
            c = 1'b0; // [RL5]
          end
        end
        MODE_ADDR2:
        begin
          ph = PH_IDLE;
          if (!st.cmd)
          begin
            c = 1'b0; // [RL10]
          end
          else if (!c && on_hit)
          begin
            // off address also passed after the on address: net result stays off
            c = !(st.off_addr != st.on_addr && between(st.off_addr, st.on_addr, cur)); // [RL9] [RL11]
          end
          else if (c && off_hit)
          begin
            c = st.off_addr != st.on_addr && between(st.on_addr, st.off_addr, cur); // [RL9] [RL11]
          end
        end
        MODE_OS_EN, MODE_OS_DIS:
        begin
          // idle one-shot keeps the clutch off; command fall is not looked at
          if (ph == PH_IDLE)
          begin
            c = 1'b0; // [RL18]
            if (st.mode == MODE_OS_EN && rise)
            begin
              b = cur; // [RL15] [RL16]
              next_st.pre_amt = st.off_addr; // [RL20]
              next_st.post_amt = st.on_addr; // [RL19]
              ph = PH_PRE;
            end
          end
          // pre and post checks chain so both can complete in one cycle
          if (ph == PH_PRE && reached(cur - b, next_st.pre_amt))
          begin
            b = b + next_st.pre_amt; // [RL16] [RL21]
            c = 1'b1;
            ph = PH_POST;
          end
          if (ph == PH_POST && reached(cur - b, next_st.post_amt))
          begin
            c = 1'b0; // [RL16] [RL11]
            ph = PH_IDLE;
          end
        end
        default: ;
      endcase
      if (latch)
      begin
        c = 1'b0; // [RL12]
        ph = PH_IDLE;
      end
      next_st.err_latch = latch;
      next_st.clutch = c;
      next_st.status = c; // [RL3]
      next_st.phase = ph;
      next_st.base = b;
      next_st.cmd_prev = st.cmd;
      next_st.mode_prev = st.mode;
      next_st.prev_pos = cur;
      next_st.pos_valid = 1'b1;
    end

    // servo off honoured only once status reads off
    next_st.servo_ok = servo_off_req && !next_st.status; // [RL13]
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.mode <= RST_MODE;
      st.mode_prev <= RST_MODE;
      st.pos_sel <= RST_SEL;
      st.on_addr <= RST_ADDR;
      st.off_addr <= RST_ADDR;
      st.phase <= PH_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign clutch_on = st.clutch;
  assign clutch_status = st.status;
  assign servo_off_ok = st.servo_ok;

  // checks
  a_mode_reject: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
    wr_ctrl && pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB] > MODE_MAX |=> $stable(st.mode) && st.mode_err)
    else $error("invalid mode code was accepted");
  a_mode_accept: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
    wr_ctrl && pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB] <= MODE_MAX
    |=> st.mode == $past(pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB]))
    else $error("valid mode code not taken");
  a_status_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
    !op_tick |=> $stable(clutch_status))
    else $error("status changed outside an operation cycle");
  a_status_match: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
    op_tick |=> clutch_status == clutch_on)
    else $error("status not refreshed with clutch");
  a_addr_on: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
    tick_ok && st.mode == MODE_ADDR && st.cmd && on_hit |=> clutch_on)
    else $error("address mode failed to engage");
  a_addr_off: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
    tick_ok && st.mode == MODE_ADDR && !st.cmd && off_hit |=> !clutch_on)
    else $error("address mode failed to release");
  a_alt_on: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
    tick_ok && st.mode == MODE_ADDR2 && st.cmd && !st.clutch && on_hit
    && !between(st.off_addr, st.on_addr, cur) |=> clutch_on)
    else $error("alternating mode failed to engage");
  a_alt_cmd_off: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
    op_tick && st.mode == MODE_ADDR2 && !st.cmd |=> !clutch_on)
    else $error("alternating mode kept clutch with command off");
  a_error_release: assert property (@(posedge pclk) disable iff (!presetn) // [RL12]
    op_tick && major_err && st.err_en |=> !clutch_on && st.err_latch)
    else $error("major error did not release clutch");
  a_servo_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
    servo_off_ok |-> !clutch_status && $past(servo_off_req))
    else $error("servo off granted with clutch on");
  a_mode4_off: assert property (@(posedge pclk) disable iff (!presetn) // [RL18]
    op_tick && st.mode == MODE_OS_DIS && st.phase == PH_IDLE |=> !clutch_on)
    else $error("mode 4 engaged without a running sequence");
  a_zero_pre: assert property (@(posedge pclk) disable iff (!presetn) // [RL21]
    tick_ok && st.mode == MODE_OS_EN && st.phase == PH_IDLE && rise
    && st.off_addr == 32'h00000000 && st.on_addr != 32'h00000000 |=> clutch_on)
    else $error("zero pre-engage travel did not engage at once");

endmodule : clutch_ctrl

// ==== dv/drive_axis.sv ====
// partner model of the virtual drive axis: positions plus the operation-cycle tick
// assumes the bench calls step once per operation cycle, never two calls at once
`timescale 1ns/1ps

module drive_axis (
  // clock
  input wire logic pclk,
  // drive outputs
  output logic op_tick,
  output clutch_pkg::axis_pos_type axis_pos
);
  import clutch_pkg::*;

  // quiet axis at time zero
  initial
  begin
    op_tick = 1'b0;
    axis_pos = '0;
  end

  // one tick per call; diff and rev sit at distinct offsets so a wrong source shows
  // positions are passed through as given; the bench table spans both directions, from -25 to 512
  task automatic step(input logic signed [31:0] p);
    @(posedge pclk);
    op_tick <= 1'b1;
    axis_pos <= '{virt: p, diff: p + 32'sd1000, rev: p - 32'sd500};
    @(posedge pclk);
    op_tick <= 1'b0;
    @(posedge pclk);
  endtask : step

endmodule : drive_axis

// ==== dv/tb_virtual_clutch_control.sv ====
// self-checking bench for the clutch controller: table of operation cycles, then edge cases
// assumes the drive_axis partner and apb answers within a bounded number of cycles
`timescale 1ns/1ps

module tb_virtual_clutch_control;
  import clutch_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, major_err, servo_off_req, err_flag;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic pready, pslverr, op_tick, servo_off_ok, clutch_on, clutch_status;
  axis_pos_type axis_pos;
  int err_count, total_checks;
  typedef struct {logic cmd; logic [2:0] m; logic [1:0] s; int on_a; int off_a; int p; logic e;}
    step_type;
  // cmd, mode, source, on word, off word, position, expected clutch
  step_type tab[48] = '{
    // single-span hits and misses, each primed by a quiet tick
    '{0,0,0,10,50,5,0}, '{1,1,0,10,50,12,1}, '{0,0,0,10,50,5,0}, '{1,1,0,10,50,9,0},
    '{0,0,0,10,50,5,0}, '{0,1,0,10,50,12,0}, '{0,0,0,10,50,20,0}, '{1,1,0,10,50,10,1},
    '{0,0,0,1010,50,0,0}, '{1,1,1,1010,50,12,1}, '{0,0,0,10,50,5,0}, '{1,2,0,10,50,12,1},
    '{0,0,0,100,0,5,0}, '{1,3,0,100,0,6,1}, '{0,0,0,0,0,5,0}, '{1,4,0,0,0,6,0},
    // mode change while engaged, signed off word
    '{1,0,0,10,-20,6,1}, '{0,1,0,10,-20,30,1}, '{0,1,0,10,-20,-25,0},
    // alternation, pass-through of both words, command drop
    '{1,2,0,10,20,0,0}, '{1,2,0,10,20,30,0}, '{1,2,0,10,20,11,0}, '{1,2,0,10,20,9,1},
    '{1,2,0,10,20,15,1}, '{1,2,0,10,20,25,0}, '{1,2,0,10,20,15,0}, '{1,2,0,10,20,9,1},
    '{0,2,0,10,20,9,0},
    // one-shot forward, command falls mid-sequence
    '{0,3,0,4,5,100,0}, '{1,3,0,4,5,100,0}, '{1,3,0,4,5,103,0}, '{1,3,0,4,5,105,1},
    '{0,3,0,4,5,107,1}, '{0,3,0,4,5,109,0},
    // switch to mode 4 mid-sequence, later rise ignored
    '{1,3,0,4,5,109,0}, '{1,3,0,4,5,114,1}, '{1,4,0,4,5,116,1}, '{1,4,0,4,5,118,0},
    '{0,4,0,4,5,118,0}, '{1,4,0,4,5,200,0},
    // one-shot backward
    '{0,3,0,-3,-2,200,0}, '{1,3,0,-3,-2,200,0}, '{1,3,0,-3,-2,198,1}, '{1,3,0,-3,-2,195,0},
    // within-revolution source, then the spare select code falling back to virt
    '{0,0,2,10,50,505,0}, '{1,1,2,10,50,512,1}, '{0,0,3,10,50,5,0}, '{1,1,3,10,50,12,1}
  };

  clutch_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_tick, .axis_pos, .major_err, .servo_off_req, .servo_off_ok,
    .clutch_on, .clutch_status);

  drive_axis axis_u (.pclk, .op_tick, .axis_pos);

  // 250 MHz clock, low at time zero
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic stop_test;
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic clu(input logic e);
    chk("clutch_on", 32'(clutch_on), 32'(e));
    chk("clutch_status", 32'(clutch_status), 32'(e));
  endtask : clu

  // one apb transfer; request held until pready is sampled high, only the watchdog ends a wait
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err_flag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] ctl(logic c, logic [2:0] m, logic [1:0] s, logic e);
    ctl = (32'(c) << CTRL_CMD_BIT) | (32'(m) << CTRL_MODE_LSB) | (32'(s) << CTRL_SEL_LSB)
      | (32'(e) << CTRL_ERREN_BIT);
  endfunction : ctl

  task automatic rst;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst

  // watchdog sized well above the expected run length
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    stop_test();
  end

  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    major_err = 1'b0;
    servo_off_req = 1'b0;
    err_count = 0;
    total_checks = 0;
    rst();
    axis_u.step(0);
    // table rows: addresses first, then control, then one operation cycle
    foreach (tab[i])
    begin
      apb(1'b1, REG_ON_ADDR, tab[i].on_a);
      apb(1'b1, REG_OFF_ADDR, tab[i].off_a);
      apb(1'b1, REG_CTRL, ctl(tab[i].cmd, tab[i].m, tab[i].s, 1'b0));
      axis_u.step(tab[i].p);
      clu(tab[i].e);
    end
    // refused mode code keeps the previous one, unmapped address errors
    apb(1'b1, REG_CTRL, ctl(1'b0, 3'h1, 2'h0, 1'b0));
    apb(1'b1, REG_CTRL, ctl(1'b0, 3'h7, 2'h0, 1'b0));
    apb(1'b0, REG_CTRL, 32'h00000000);
    chk("ctrl mode", 32'(rd[CTRL_MODE_MSB:CTRL_MODE_LSB]), 32'h00000001);
    apb(1'b0, REG_STATUS, 32'h00000000);
    chk("mode error", 32'(rd[STAT_MODEERR_BIT]), 32'h00000001);
    apb(1'b0, 12'h010, 32'h00000000);
    chk("unmapped error", 32'(err_flag), 32'h00000001);
    chk("unmapped data", rd, 32'h00000000);
    // mode error clears when a one is written to its status bit
    apb(1'b1, REG_STATUS, 32'h00000001 << STAT_MODEERR_BIT);
    apb(1'b0, REG_STATUS, 32'h00000000);
    chk("mode error cleared", 32'(rd[STAT_MODEERR_BIT]), 32'h00000000);
    // major error release, resume only after command off then on
    apb(1'b1, REG_CTRL, ctl(1'b1, 3'h0, 2'h0, 1'b1));
    axis_u.step(0);
    clu(1'b1);
    @(posedge pclk);
    major_err <= 1'b1;
    axis_u.step(0);
    clu(1'b0);
    major_err <= 1'b0;
    axis_u.step(0);
    clu(1'b0);
    apb(1'b1, REG_CTRL, ctl(1'b0, 3'h0, 2'h0, 1'b1));
    axis_u.step(0);
    apb(1'b1, REG_CTRL, ctl(1'b1, 3'h0, 2'h0, 1'b1));
    axis_u.step(0);
    clu(1'b1);
    // servo off refused while engaged, granted once status is off
    servo_off_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("servo off ok", 32'(servo_off_ok), 32'h00000000);
    apb(1'b1, REG_CTRL, ctl(1'b0, 3'h0, 2'h0, 1'b0));
    axis_u.step(0);
    @(posedge pclk);
    chk("servo off ok", 32'(servo_off_ok), 32'h00000001);
    // host brings the axis back before raising the command
    servo_off_req <= 1'b0;
    apb(1'b1, REG_CTRL, ctl(1'b1, 3'h0, 2'h0, 1'b0));
    axis_u.step(0);
    clu(1'b1);
    // release not selected: a major error leaves the clutch engaged
    major_err <= 1'b1;
    axis_u.step(0);
    clu(1'b1);
    major_err <= 1'b0;
    // second reset in mid-run clears registers and clutch
    rst();
    clu(1'b0);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b0, 12'(4 * k), 32'h00000000);
      chk("register reset value", rd, 32'h00000000);
    end
    stop_test();
  end

endmodule : tb_virtual_clutch_control
